// ---- core/exec_pkg.sv ----
package exec_pkg;

	// Prefix and opcode bytes seen by the decoder.
	localparam logic [7:0] PFX_EXTENDED = 8'hed;
	localparam logic [7:0] PFX_INDEX_X = 8'hdd;
	localparam logic [7:0] PFX_INDEX_Y = 8'hfd;
	localparam logic [7:0] OPC_DIGIT_ROTATE = 8'h67;
	localparam logic [7:0] OPC_SUB_IMMEDIATE = 8'hde;
	localparam logic [4:0] OPC_SUB_GROUP = 5'h13;
	localparam logic [1:0] OPC_RESTART_TOP = 2'h3;
	localparam logic [2:0] OPC_RESTART_LOW = 3'h7;
	localparam int PFX_INDEX_SELECT_BIT = 5;

	// Three-bit operand fields of the subtract group.
	localparam logic [2:0] FLD_ZERO = 3'h0;
	localparam logic [2:0] FLD_PAIR_X = 3'h1;
	localparam logic [2:0] FLD_PAIR_Y = 3'h2;
	localparam logic [2:0] FLD_PAIR_XY = 3'h3;
	localparam logic [2:0] FLD_INDEX_HIGH = 3'h4;
	localparam logic [2:0] FLD_INDEX_LOW = 3'h5;
	localparam logic [2:0] FLD_MEMORY = 3'h6;
	localparam logic [2:0] FLD_DIRECT = 3'h7;

	// Flag byte layout.
	localparam int FLAG_S = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_H = 4;
	localparam int FLAG_PV = 2;
	localparam int FLAG_N = 1;
	localparam int FLAG_C = 0;

	localparam logic [15:0] STACK_STEP = 16'h0002;

	// Register map of the plain software port.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_LAST_FLAGS = 4'h8;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_ILLEGAL_BIT = 1;

	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_CAPTURE, ST_PUSH_HIGH} exec_state_e;
	typedef enum logic [1:0] {K_NONE, K_ROTATE, K_SUBTRACT, K_RESTART} op_kind_e;

	typedef struct packed {
		logic hasPrefix;
		logic [7:0] prefix;
		logic [7:0] opcode;
		logic [7:0] ext0;
		logic [7:0] ext1;
	} instr_s;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] f;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] h;
		logic [7:0] l;
		logic [15:0] ix;
		logic [15:0] iy;
		logic [15:0] sp;
		logic [15:0] pc;
	} regs_s;

	typedef struct packed {
		logic done;
		logic illegal;
		logic accWe;
		logic flagsWe;
		logic spWe;
		logic pcWe;
		logic [7:0] acc;
		logic [7:0] flags;
		logic [15:0] sp;
		logic [15:0] pc;
	} result_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_s;

	typedef struct packed {
		exec_state_e st;
		op_kind_e kind;
		logic execDisable;
		logic illegalSticky;
		logic busy;
		logic [7:0] acc;
		logic [7:0] flags;
		logic [7:0] src;
		logic [15:0] addr;
		logic [7:0] lastFlags;
		logic [7:0] rdData;
		result_s res;
		mem_s mem;
	} state_s;

endpackage

// ---- core/digit_rotate_restart_subtract_exec.sv ----
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module digit_rotate_restart_subtract_exec
	import exec_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic instValid,
	input wire instr_s instData,
	input wire regs_s regs,
	input wire logic [7:0] memRdata,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	output logic busy,
	output result_s result,
	output mem_s mem
);

	state_s q;
	state_s n;

	function automatic logic [7:0] regByte(input logic [2:0] sel, input regs_s r);
		case (sel)
			3'h0: regByte = r.b;
			3'h1: regByte = r.c;
			3'h2: regByte = r.d;
			3'h3: regByte = r.e;
			3'h4: regByte = r.h;
			3'h5: regByte = r.l;
			3'h7: regByte = r.a;
			default: regByte = 8'h00;
		endcase
	endfunction

	function automatic logic [15:0] pairBase(input logic [2:0] sel, input regs_s r);
		case (sel)
			FLD_PAIR_X: pairBase = r.ix;
			FLD_PAIR_Y: pairBase = r.iy;
			default: pairBase = {r.h, r.l};
		endcase
	endfunction

	// Returns the new accumulator in the high byte and new flags in the low byte.
	function automatic logic [15:0] subtractWithBorrow(input logic [7:0] a,
		input logic [7:0] s, input logic [7:0] f);
		logic [8:0] diff;
		logic [4:0] low;
		logic [7:0] fo;
		diff = {1'b0, a} - {1'b0, s} - {8'h00, f[FLAG_C]};
		low = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, f[FLAG_C]};
		fo = f;
		fo[FLAG_S] = diff[7];
		fo[FLAG_Z] = (diff[7:0] == 8'h00);
		fo[FLAG_H] = low[4];
		fo[FLAG_PV] = (a[7] != s[7]) && (diff[7] == s[7]);
		fo[FLAG_N] = 1'b1;
		fo[FLAG_C] = diff[8];
		subtractWithBorrow = {diff[7:0], fo};
	endfunction

	function automatic logic [7:0] rotateFlags(input logic [7:0] acc, input logic [7:0] f);
		logic [7:0] fo;
		fo = f;
		fo[FLAG_S] = acc[7];
		fo[FLAG_Z] = (acc == 8'h00);
		fo[FLAG_H] = 1'b0;
		fo[FLAG_PV] = ~^acc;
		fo[FLAG_N] = 1'b0;
		rotateFlags = fo;
	endfunction

	logic decodeNow;
	logic rotateHit;
	logic restartHit;
	logic plainSubHit;
	logic indexSubHit;
	logic [2:0] field;
	logic [15:0] indexReg;
	logic [15:0] disp16;
	logic [15:0] subPair;
	logic [7:0] rotAcc;

	assign decodeNow = instValid && (q.st == ST_IDLE) && !q.execDisable;
	assign field = instData.opcode[2:0];
	assign rotateHit = instData.hasPrefix && (instData.prefix == PFX_EXTENDED) &&
		(instData.opcode == OPC_DIGIT_ROTATE);
	assign restartHit = !instData.hasPrefix && (instData.opcode[7:6] == OPC_RESTART_TOP) &&
		(instData.opcode[2:0] == OPC_RESTART_LOW);
	assign plainSubHit = !instData.hasPrefix && (instData.opcode[7:3] == OPC_SUB_GROUP);
	assign indexSubHit = instData.hasPrefix && (instData.opcode[7:3] == OPC_SUB_GROUP) &&
		((instData.prefix == PFX_INDEX_X) || (instData.prefix == PFX_INDEX_Y));
	assign indexReg = instData.prefix[PFX_INDEX_SELECT_BIT] ? regs.iy : regs.ix;
	assign disp16 = {instData.ext1, instData.ext0};
	assign subPair = (field == FLD_PAIR_XY) ? regs.ix + regs.iy :
		{regs.h, regs.l} + pairBase(field, regs);
	assign rotAcc = {q.acc[7:4], memRdata[7:4]};

	always_comb begin
		n = q;
		n.res.done = 1'b0;
		n.res.illegal = 1'b0;
		n.res.accWe = 1'b0;
		n.res.flagsWe = 1'b0;
		n.res.spWe = 1'b0;
		n.res.pcWe = 1'b0;
		n.mem.rd = 1'b0;
		n.mem.wr = 1'b0;
		n.rdData = 8'h00;
		if (regRd) begin
			unique case (regAddr)
				REG_CTRL: n.rdData[CTRL_ENABLE_BIT] = !q.execDisable;
				REG_STATUS: begin
					n.rdData[STATUS_BUSY_BIT] = q.busy;
					n.rdData[STATUS_ILLEGAL_BIT] = q.illegalSticky;
				end
				REG_LAST_FLAGS: n.rdData = q.lastFlags;
				default: n.rdData = 8'h00;
			endcase
		end
		if (regWr && regAddr == REG_CTRL) begin
			n.execDisable = !regWdata[CTRL_ENABLE_BIT];
		end
		if (regWr && regAddr == REG_STATUS && regWdata[STATUS_ILLEGAL_BIT]) begin
			n.illegalSticky = 1'b0;
		end
		unique case (q.st)
			ST_IDLE: begin
				if (decodeNow) begin
					n.acc = regs.a;
					n.flags = regs.f;
					n.kind = K_SUBTRACT;
					n.mem.addr = {regs.h, regs.l};
					if (rotateHit) begin
						n.kind = K_ROTATE;
						n.mem.addr = {regs.h, regs.l};
						n.st = ST_ISSUE;
					end else if (restartHit) begin
						n.kind = K_RESTART;
						n.src = {2'h0, instData.opcode[5:3], 3'h0};
						n.addr = regs.sp - STACK_STEP;
						n.mem.addr = regs.sp - STACK_STEP;
						n.mem.wdata = regs.pc[7:0];
						n.mem.wr = 1'b1;
						n.st = ST_PUSH_HIGH;
					end else if (plainSubHit && field != FLD_MEMORY) begin
						n.src = regByte(field, regs);
						{n.res.acc, n.res.flags} = subtractWithBorrow(regs.a, n.src, regs.f);
						n.res.done = 1'b1;
					end else if (plainSubHit) begin
						n.st = ST_ISSUE;
					end else if (!instData.hasPrefix && instData.opcode == OPC_SUB_IMMEDIATE) begin
						n.src = instData.ext0;
						{n.res.acc, n.res.flags} = subtractWithBorrow(regs.a, n.src, regs.f);
						n.res.done = 1'b1;
					end else if (indexSubHit) begin
						n.st = ST_ISSUE;
						unique case (field)
							FLD_ZERO: n.mem.addr = instData.prefix[PFX_INDEX_SELECT_BIT] ?
								regs.pc + disp16 : regs.sp + disp16;
							FLD_PAIR_X, FLD_PAIR_Y, FLD_PAIR_XY:
								n.mem.addr = instData.prefix[PFX_INDEX_SELECT_BIT] ?
									pairBase(field, regs) + disp16 : subPair;
							FLD_INDEX_HIGH, FLD_INDEX_LOW: begin
								n.st = ST_IDLE;
								n.src = (field == FLD_INDEX_HIGH) ? indexReg[15:8] :
									indexReg[7:0];
								{n.res.acc, n.res.flags} = subtractWithBorrow(regs.a, n.src,
									regs.f);
								n.res.done = 1'b1;
							end
							FLD_MEMORY: n.mem.addr = indexReg + {{8{instData.ext0[7]}},
								instData.ext0};
							FLD_DIRECT: begin
								n.mem.addr = disp16;
								if (instData.prefix[PFX_INDEX_SELECT_BIT]) begin
									n.st = ST_IDLE;
									n.res.done = 1'b1;
									n.res.illegal = 1'b1;
								end
							end
						endcase
					end else begin
						n.kind = K_NONE;
						n.res.done = 1'b1;
						n.res.illegal = 1'b1;
					end
					n.mem.rd = (n.st == ST_ISSUE);
					n.res.accWe = n.res.done && !n.res.illegal;
					n.res.flagsWe = n.res.accWe;
				end else if (instValid && q.st == ST_IDLE) begin
					// A refused request must not leave the last instruction's kind behind.
					n.kind = K_NONE;
					n.res.done = 1'b1;
					n.res.illegal = 1'b1;
				end
			end
			ST_ISSUE: n.st = ST_CAPTURE;
			ST_CAPTURE: begin
				n.st = ST_IDLE;
				n.res.done = 1'b1;
				n.res.accWe = 1'b1;
				n.res.flagsWe = 1'b1;
				if (q.kind == K_ROTATE) begin
					n.src = memRdata;
					n.res.acc = rotAcc;
					n.res.flags = rotateFlags(rotAcc, q.flags);
					n.mem.wr = 1'b1;
					n.mem.wdata = {memRdata[3:0], q.acc[3:0]};
				end else begin
					n.src = memRdata;
					{n.res.acc, n.res.flags} = subtractWithBorrow(q.acc, memRdata, q.flags);
				end
			end
			ST_PUSH_HIGH: begin
				n.st = ST_IDLE;
				n.mem.wr = 1'b1;
				n.mem.addr = q.addr + 16'h0001;
				n.mem.wdata = regs.pc[15:8];
				n.res.done = 1'b1;
				n.res.spWe = 1'b1;
				n.res.sp = q.addr;
				n.res.pcWe = 1'b1;
				n.res.pc = {8'h00, q.src};
			end
		endcase
		if (n.res.illegal) begin
			n.illegalSticky = 1'b1;
		end
		if (n.res.flagsWe) begin
			n.lastFlags = n.res.flags;
		end
		n.busy = (n.st != ST_IDLE);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else if (ce) begin
			q <= n;
		end
	end

	assign regRdata = q.rdData;
	assign busy = q.busy;
	assign result = q.res;
	assign mem = q.mem;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence rotDecode;
		ce && decodeNow && rotateHit;
	endsequence

	sequence rstDecode;
		ce && decodeNow && restartHit;
	endsequence

	sequence rstStart;
		rstDecode ##1 ce;
	endsequence

	rot_read_addr_a: assert property (
		rotDecode |=> mem.rd && mem.addr == $past({regs.h, regs.l}))
		else $error("digit rotate read wrong address");

	rot_acc_value_a: assert property (
		(ce && q.st == ST_CAPTURE && q.kind == K_ROTATE) |=>
			result.done && result.acc == {$past(q.acc[7:4]), $past(memRdata[7:4])})
		else $error("digit rotate accumulator wrong");

	rot_mem_value_a: assert property (
		(ce && q.st == ST_CAPTURE && q.kind == K_ROTATE) |=>
			mem.wr && mem.wdata == {$past(memRdata[3:0]), $past(q.acc[3:0])})
		else $error("digit rotate memory byte wrong");

	rot_flags_a: assert property (
		(result.done && result.flagsWe && q.kind == K_ROTATE) |->
			!result.flags[FLAG_H] && !result.flags[FLAG_N] &&
			result.flags[FLAG_C] == q.flags[FLAG_C] &&
			result.flags[FLAG_PV] == ~^result.acc && result.flags[FLAG_S] == result.acc[7])
		else $error("digit rotate flags wrong");

	rst_push_low_a: assert property (
		rstDecode |=> mem.wr && mem.addr == $past(regs.sp) - STACK_STEP &&
			mem.wdata == $past(regs.pc[7:0]))
		else $error("restart push address wrong");

	rst_vector_a: assert property (
		rstStart |=> result.pcWe && result.done &&
			result.pc == {8'h00, 2'h0, $past(instData.opcode[5:3], 2), 3'h0})
		else $error("restart vector wrong");

	rst_flags_kept_a: assert property (
		(result.done && q.kind == K_RESTART) |-> !result.flagsWe && result.spWe)
		else $error("restart touched flags");

	sub_value_a: assert property (
		(result.done && result.accWe && q.kind == K_SUBTRACT) |->
			{result.flags[FLAG_C], result.acc} ==
				{1'b0, q.acc} - {1'b0, q.src} - {8'h00, q.flags[FLAG_C]})
		else $error("subtract result or carry wrong");

	sub_zero_sign_a: assert property (
		(result.done && result.accWe && q.kind == K_SUBTRACT) |->
			result.flags[FLAG_Z] == (result.acc == 8'h00) && result.flags[FLAG_N] &&
			result.flags[FLAG_S] == result.acc[7])
		else $error("subtract zero or sign wrong");

	sub_overflow_a: assert property (
		(result.done && result.accWe && q.kind == K_SUBTRACT) |->
			result.flags[FLAG_PV] == ((q.acc[7] ^ q.src[7]) && (result.acc[7] == q.src[7])))
		else $error("subtract overflow wrong");

	sub_no_write_a: assert property (
		(q.kind == K_SUBTRACT) |-> !mem.wr)
		else $error("subtract wrote memory");

	rot_decode_a: assert property (
		(ce && decodeNow && instData.hasPrefix && instData.prefix == PFX_EXTENDED &&
			instData.opcode == OPC_DIGIT_ROTATE) |=> q.kind == K_ROTATE && mem.rd && busy)
		else $error("digit rotate not decoded");

	rot_zero_flag_a: assert property (
		(result.done && result.flagsWe && q.kind == K_ROTATE) |->
			result.flags[FLAG_Z] == (result.acc == 8'h00) && !result.spWe && !result.pcWe)
		else $error("digit rotate zero flag wrong");

	rst_push_high_a: assert property (
		rstStart |=> mem.wr && mem.wdata == $past(regs.pc[15:8]) &&
			mem.addr == $past(regs.sp, 2) - STACK_STEP + 16'h0001 &&
			result.sp == $past(regs.sp, 2) - STACK_STEP)
		else $error("restart push high byte wrong");

	sub_half_borrow_a: assert property (
		(result.done && result.accWe && q.kind == K_SUBTRACT) |->
			result.flags[FLAG_H] ==
				({1'b0, q.acc[3:0]} < {1'b0, q.src[3:0]} + {4'h0, q.flags[FLAG_C]}))
		else $error("subtract half borrow wrong");

	sub_reg_value_a: assert property (
		(ce && decodeNow && plainSubHit && field != FLD_MEMORY) |=>
			result.done && result.accWe && !busy &&
			result.acc == $past(regs.a) - $past(regByte(field, regs)) -
				{7'h00, $past(regs.f[FLAG_C])})
		else $error("register subtract result wrong");

	idx_byte_high_a: assert property (
		(ce && decodeNow && indexSubHit && field == FLD_INDEX_HIGH) |=>
			result.accWe && q.src == ($past(instData.prefix == PFX_INDEX_Y) ?
				$past(regs.iy[15:8]) : $past(regs.ix[15:8])))
		else $error("index high byte source wrong");

	idx_byte_low_a: assert property (
		(ce && decodeNow && indexSubHit && field == FLD_INDEX_LOW) |=>
			result.accWe && q.src == ($past(instData.prefix == PFX_INDEX_Y) ?
				$past(regs.iy[7:0]) : $past(regs.ix[7:0])))
		else $error("index low byte source wrong");

endmodule

// ---- test/exec_mem_model.sv ----
`timescale 1ns/1ps
module exec_mem_model
	import exec_pkg::*;
(
	input wire logic clk,
	input wire mem_s mem,
	output logic [7:0] memRdata
);
	logic [7:0] m [logic [15:0]];
	initial memRdata = 8'h00;
	// Outside the answer cycle the bus flips, so a late sample cannot match by luck.
	always @(posedge clk) begin
		if (mem.rd)
			memRdata <= m.exists(mem.addr) ? m[mem.addr] : 8'h00;
		else
			memRdata <= ~memRdata;
		if (mem.wr)
			m[mem.addr] = mem.wdata;
	end
endmodule

// ---- test/digit_rotate_restart_subtract_exec_bench.sv ----
`timescale 1ns/1ps
module digit_rotate_restart_subtract_exec_bench
	import exec_pkg::*;
;
	logic clk = 0, resetn = 0, ce = 1, instValid = 0, regWr = 0, regRd = 0;
	instr_s instData = '0;
	regs_s regs = '0;
	regs_s base;
	logic [7:0] memRdata, regRdata;
	logic [7:0] regWdata = 8'h00;
	logic [3:0] regAddr = 4'h0;
	logic busy;
	result_s result;
	mem_s mem;
	logic [15:0] rdAddr;
	int miscompares = 0, comparisons = 0, wrCount, doneAt, busyCount;

	digit_rotate_restart_subtract_exec dut_u (.clk(clk), .resetn(resetn), .ce(ce),
		.instValid(instValid), .instData(instData), .regs(regs), .memRdata(memRdata),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .busy(busy), .result(result), .mem(mem));
	exec_mem_model mem_u (.clk(clk), .mem(mem), .memRdata(memRdata));

	initial begin
		forever #20 clk = ~clk;
	end

	task check(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s is %h, expected %h", $time, what, got, exp);
		end
	endtask

	function logic [7:0] subFlags(input logic [7:0] a, input logic [7:0] s, input logic [7:0] f);
		logic [8:0] d;
		d = {1'b0, a} - {1'b0, s} - {8'h00, f[FLAG_C]};
		subFlags = f;
		subFlags[FLAG_S] = d[7];
		subFlags[FLAG_Z] = (d[7:0] == 8'h00);
		subFlags[FLAG_H] = {1'b0, a[3:0]} < ({1'b0, s[3:0]} + {4'h0, f[FLAG_C]});
		subFlags[FLAG_PV] = (a[7] != s[7]) && (d[7] == s[7]);
		subFlags[FLAG_N] = 1'b1;
		subFlags[FLAG_C] = d[8];
	endfunction

	task exec(input instr_s i, input regs_s rg, output result_s r);
		int k;
		@(posedge clk);
		instData <= i;
		regs <= rg;
		instValid <= 1'b1;
		@(posedge clk);
		instValid <= 1'b0;
		wrCount = 0;
		busyCount = 0;
		rdAddr = 16'h0000;
		for (k = 0; k < 8; k++) begin
			#1;
			if (mem.rd === 1'b1)
				rdAddr = mem.addr;
			if (mem.wr === 1'b1)
				wrCount++;
			if (busy === 1'b1)
				busyCount++;
			if (result.done === 1'b1)
				break;
			@(posedge clk);
		end
		doneAt = k;
		r = result;
		check({15'h0, r.done}, 16'h1, "done");
	endtask

	task regWrite(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task regRead(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		check(regRdata, exp, "register read");
	endtask

	task runSub(input logic [7:0] pfx, input logic [7:0] op, input logic [7:0] e0,
		input logic [7:0] src, input logic [15:0] addr);
		instr_s i;
		result_s r;
		i = '{hasPrefix: pfx != 8'h00, prefix: pfx, opcode: op, ext0: e0, ext1: 8'h00};
		if (addr != 16'h0000)
			mem_u.m[addr] = src;
		exec(i, base, r);
		check(r.acc, 8'(base.a - src - {7'h0, base.f[FLAG_C]}), "difference");
		check(r.flags, subFlags(base.a, src, base.f), "subtract flags");
		check(rdAddr, addr, "operand address");
		check(16'(wrCount), 16'h0, "operand writes");
		check({14'h0, r.accWe, r.illegal}, 16'h2, "subtract enables");
		check(16'(doneAt), (addr != 16'h0000) ? 16'h2 : 16'h0, "subtract latency");
		check(16'(busyCount), (addr != 16'h0000) ? 16'h2 : 16'h0, "subtract busy");
	endtask

	task rotateDigit;
		regs_s rg;
		result_s r;
		rg = base;
		rg.a = 8'h84;
		rg.h = 8'h50;
		rg.l = 8'h00;
		mem_u.m[16'h5000] = 8'h32;
		exec('{1'b1, PFX_EXTENDED, OPC_DIGIT_ROTATE, 8'h00, 8'h00}, rg, r);
		check(rdAddr, 16'h5000, "rotate address");
		check(r.acc, 8'h83, "rotate acc");
		check(r.flags, 8'h81, "rotate flags");
		check(16'(doneAt), 16'h2, "rotate latency");
		check(16'(busyCount), 16'h2, "rotate busy");
		check(16'(wrCount), 16'h1, "rotate writes");
		@(posedge clk);
		#1;
		check(mem_u.m[16'h5000], 8'h24, "rotate byte");
		regRead(REG_LAST_FLAGS, 8'h81);
	endtask

	task restartAll;
		regs_s rg;
		result_s r;
		for (int t = 0; t < 8; t++) begin
			rg = base;
			rg.pc = 16'h4620;
			rg.sp = 16'hffc4;
			exec('{1'b0, 8'h00, {OPC_RESTART_TOP, 3'(t), OPC_RESTART_LOW}, 8'h00, 8'h00}, rg, r);
			check(r.pc, 16'(t * 8), "vector");
			check(r.sp, 16'hffc2, "stack");
			check({13'h0, r.pcWe, r.spWe, r.flagsWe}, 16'h6, "restart enables");
			check(16'(doneAt), 16'h1, "restart latency");
			check(16'(busyCount), 16'h1, "restart busy");
			check(16'(wrCount), 16'h2, "restart writes");
			@(posedge clk);
			#1;
			check({mem_u.m[16'hffc3], mem_u.m[16'hffc2]}, 16'h4620, "pushed pc");
		end
	endtask

	task refusals;
		result_s r;
		regWrite(REG_CTRL, 8'h00);
		exec('{1'b1, PFX_EXTENDED, OPC_DIGIT_ROTATE, 8'h00, 8'h00}, base, r);
		check({14'h0, r.illegal, r.accWe}, 16'h2, "disabled");
		regRead(REG_STATUS, 8'h02);
		regWrite(REG_STATUS, 8'h02);
		regRead(REG_STATUS, 8'h00);
		regWrite(REG_CTRL, 8'h01);
		exec('{1'b1, PFX_INDEX_Y, 8'h9f, 8'h00, 8'h00}, base, r);
		check({14'h0, r.illegal, r.accWe}, 16'h2, "undecodable");
		regRead(4'hc, 8'h00);
		regRead(REG_CTRL, 8'h01);
	endtask

	// A request held while the clock enable is low must wait, then be taken once.
	task freezeHold;
		@(posedge clk);
		ce <= 1'b0;
		instData <= '{1'b0, 8'h00, 8'h98, 8'h00, 8'h00};
		regs <= base;
		instValid <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check({14'h0, result.done, busy}, 16'h0, "frozen request");
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		instValid <= 1'b0;
		#1;
		check({15'h0, result.done}, 16'h1, "thawed request");
		check(result.acc, 8'(base.a - base.b - {7'h0, base.f[FLAG_C]}), "thawed value");
	endtask

	task give_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		give_verdict();
	end

	initial begin
		base = '0;
		base.a = 8'h48;
		base.f = 8'h01;
		base.b = 8'h18;
		base.h = 8'h20;
		base.ix = 16'h0130;
		base.iy = 16'h0250;
		base.sp = 16'h3000;
		base.pc = 16'h4000;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rotateDigit();
		restartAll();
		runSub(8'h00, 8'h98, 8'h00, 8'h18, 16'h0000);
		runSub(8'h00, 8'h9e, 8'h00, 8'h18, 16'h2000);
		runSub(8'h00, OPC_SUB_IMMEDIATE, 8'h47, 8'h47, 16'h0000);
		runSub(PFX_INDEX_X, 8'h9c, 8'h00, 8'h01, 16'h0000);
		runSub(PFX_INDEX_X, 8'h9d, 8'h00, 8'h30, 16'h0000);
		runSub(PFX_INDEX_Y, 8'h9c, 8'h00, 8'h02, 16'h0000);
		runSub(PFX_INDEX_X, 8'h9f, 8'h10, 8'h80, 16'h0010);
		runSub(PFX_INDEX_X, 8'h98, 8'h10, 8'h48, 16'h3010);
		runSub(PFX_INDEX_Y, 8'h98, 8'h10, 8'hc8, 16'h4010);
		runSub(PFX_INDEX_X, 8'h99, 8'h00, 8'h18, 16'h2130);
		runSub(PFX_INDEX_X, 8'h9a, 8'h00, 8'h80, 16'h2250);
		runSub(PFX_INDEX_X, 8'h9b, 8'h00, 8'h47, 16'h0380);
		runSub(PFX_INDEX_X, 8'h9e, 8'h10, 8'h48, 16'h0140);
		runSub(PFX_INDEX_Y, 8'h9e, 8'h10, 8'h18, 16'h0260);
		runSub(PFX_INDEX_Y, 8'h9b, 8'h10, 8'h30, 16'h2010);
		runSub(8'h00, 8'h9f, 8'h00, 8'h48, 16'h0000);
		refusals();
		freezeHold();
		give_verdict();
	end
endmodule
